// >>> xu_pkg.sv
/*
 types and constants of the alu and branch execution unit.
 assumes a classic wishbone master and an 8-bit data path.
*/
`default_nettype none
// What this block does
// RULE1: add, with or without carry in, writes sum, sets Z C N V H.
// RULE2: subtract register or constant writes difference, sets Z C N V H.
// RULE3: subtract with borrow also removes carry, sets Z C N V H.
// RULE4: and, or, xor set Z N V only; carry and half-carry kept.
// RULE5: set-bits ors the mask in, sets Z N V.
// RULE6: clear-bits ands with ff minus mask, sets Z N V.
// RULE7: zero-or-minus test ands value with itself, sets Z N V.
// RULE8: compares subtract without writing, set Z N V C H.
// RULE9: compare-skip skips on equal, pc plus 2 or 3, no flags.
// RULE10: register bit skip on bit low or high, 1 or 2 cycles.
// RULE11: io bit skip on bit low or high, pc plus 2 or 3.
// RULE12: flag branch on chosen flag, pc plus offset plus one.
// RULE13: signed branches decide on n xor v, zero or one.
// RULE14: unsigned high and carry-low on c zero, low on c one.
// RULE15: half-carry branches on h set or cleared.
// RULE16: transfer branches on t set or cleared.
// RULE17: overflow branches on v set or cleared, flags kept.
// RULE18: interrupt branches on i set or cleared, 1 or 2 cycles.
// RULE19: jump 2, call 3, returns 4 cycles; interrupt return sets i.
// RULE20: invert gives ff minus value, sets Z C N V; negate adds H.
// RULE21: inc and dec keep carry; clear sets Z N V; set all keeps flags.
package xu_pkg;
    localparam int PC_W = 12;
    typedef enum logic [5:0] {
        op_add, op_add_carry, op_sub, op_subtract_const, op_subtract_borrow,
        op_subtract_borrow_const, op_and, op_and_immediate, op_or, op_or_immediate,
        op_xor_registers, op_bitwise_invert, op_sign_flip, op_mask_set_bits,
        op_mask_clear_bits, op_add_one, op_subtract_one, op_zero_minus_check,
        op_register_zero, op_register_all_ones, op_relative_jump, op_relative_call,
        op_call_exit, op_interrupt_exit, op_compare_skip_equal, op_compare,
        op_compare_borrow, op_compare_const, op_skip_reg_bit_low, op_skip_reg_bit_high,
        op_skip_io_bit_low, op_skip_io_bit_high, op_branch_flag_high, op_branch_flag_low,
        op_branch_signed_ge, op_branch_signed_lt, op_branch_unsigned_ge,
        op_branch_unsigned_lt, op_branch_carry_low, op_branch_halfcarry_high,
        op_branch_halfcarry_low, op_branch_transfer_high, op_branch_transfer_low,
        op_branch_overflow_high, op_branch_overflow_low, op_branch_irq_on,
        op_branch_irq_off
    } op_t;
    typedef struct packed {
        logic i;
        logic t;
        logic h;
        logic s;
        logic v;
        logic n;
        logic z;
        logic c;
    } flags_t;
    typedef struct packed {
        logic long_skip;
        logic [2:0] sel;
        logic [1:0] spare;
        op_t op;
    } ctrl_t;
    typedef struct packed {
        logic [2:0] cycles;
        logic [1:0] spare;
        logic taken;
        logic busy;
    } status_t;
    typedef struct packed {
        logic [7:0] res;
        flags_t fl;
    } alu_out_t;
    typedef struct packed {
        logic [7:0] opa;
        logic [7:0] opb;
        ctrl_t ctrl;
        flags_t flags;
        logic [PC_W-1:0] pc;
        logic [PC_W-1:0] offset;
        logic [PC_W-1:0] stack;
        logic [2:0] busy_cnt;
        logic taken;
        logic [2:0] last_cyc;
        logic ack;
        logic [31:0] dat;
    } state_t;
    localparam state_t RESET_STATE = '0;
    localparam logic [4:0] OFS_OPA = 5'h00;
    localparam logic [4:0] OFS_OPB = 5'h04;
    localparam logic [4:0] OFS_CTRL = 5'h08;
    localparam logic [4:0] OFS_FLAGS = 5'h0c;
    localparam logic [4:0] OFS_PC = 5'h10;
    localparam logic [4:0] OFS_OFFSET = 5'h14;
    localparam logic [4:0] OFS_STACK = 5'h18;
    localparam logic [4:0] OFS_STATUS = 5'h1c;
    localparam logic [2:0] CYC_ONE = 3'h1;
    localparam logic [2:0] CYC_TAKEN = 3'h2;
    localparam logic [2:0] CYC_SKIP = 3'h2;
    localparam logic [2:0] CYC_JUMP = 3'h2;
    localparam logic [2:0] CYC_CALL = 3'h3;
    localparam logic [2:0] CYC_RETURN = 3'h4;
    localparam logic [7:0] ALL_ONES = 8'hff;
    localparam logic [PC_W-1:0] PC_STEP = 12'h001;
    localparam logic [PC_W-1:0] SKIP_SHORT = 12'h002;
    localparam logic [PC_W-1:0] SKIP_LONG = 12'h003;
endpackage
`default_nettype wire

// >>> alu_and_branch_execution.sv
/*
 alu and branch execution unit with a wishbone register port.
 assumes a classic wishbone master on mclk and xu_pkg compiled first.
*/
// Local design decisions: the register addresses and register access over Wishbone.
`default_nettype none
module alu_and_branch_execution (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic busy
);
    ////////////////////////////////////////////////////////////////////////
    // flag arithmetic and byte-lane merge
    function automatic xu_pkg::alu_out_t add8(
        input logic [7:0] x,
        input logic [7:0] y,
        input logic cin,
        input xu_pkg::flags_t f
    );
        logic [8:0] s;
        xu_pkg::alu_out_t o;
        s = {1'b0, x} + {1'b0, y} + {8'h00, cin};
        o.res = s[7:0];
        o.fl = f;
        o.fl.c = s[8];
        o.fl.h = (x[3] & y[3]) | (y[3] & ~s[3]) | (~s[3] & x[3]);
        o.fl.v = (x[7] & y[7] & ~s[7]) | (~x[7] & ~y[7] & s[7]);
        o.fl.n = s[7];
        o.fl.z = (s[7:0] == 8'h00);
        return o;
    endfunction

    function automatic xu_pkg::alu_out_t sub8(
        input logic [7:0] x,
        input logic [7:0] y,
        input logic cin,
        input xu_pkg::flags_t f,
        input logic zchain
    );
        logic [8:0] s;
        xu_pkg::alu_out_t o;
        s = {1'b0, x} - {1'b0, y} - {8'h00, cin};
        o.res = s[7:0];
        o.fl = f;
        o.fl.c = s[8];
        o.fl.h = (~x[3] & y[3]) | (y[3] & s[3]) | (s[3] & ~x[3]);
        o.fl.v = (x[7] & ~y[7] & ~s[7]) | (~x[7] & y[7] & s[7]);
        o.fl.n = s[7];
        o.fl.z = (s[7:0] == 8'h00) & (~zchain | f.z);
        return o;
    endfunction

    function automatic xu_pkg::alu_out_t logic8(
        input logic [7:0] r,
        input xu_pkg::flags_t f
    );
        xu_pkg::alu_out_t o;
        o.res = r;
        o.fl = f;
        o.fl.v = 1'b0;
        o.fl.n = r[7];
        o.fl.z = (r == 8'h00);
        return o;
    endfunction

    function automatic logic [31:0] lanes(
        input logic [31:0] old,
        input logic [31:0] d,
        input logic [3:0] s
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (s[i])
            begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state and bus decode
    xu_pkg::state_t st;
    xu_pkg::state_t next_st;
    logic req;
    logic start;
    logic [4:0] adr;
    logic [31:0] cm;
    xu_pkg::ctrl_t ctl;
    xu_pkg::op_t op;
    logic [7:0] fv;
    logic [2:0] sel;
    xu_pkg::alu_out_t ao;
    logic [2:0] cyc;
    logic cond;
    logic is_skip;
    logic is_br;
    logic [xu_pkg::PC_W-1:0] br_pc;
    logic [xu_pkg::PC_W-1:0] pcn;
    logic [xu_pkg::PC_W-1:0] stack_n;
    logic [31:0] rd;
    logic [31:0] m;

    assign req = wb_cyc_i & wb_stb_i & ~st.ack;
    assign adr = {wb_adr_i[4:2], 2'b00};
    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.dat;
    assign busy = (st.busy_cnt != 3'h0);

    always_comb
    begin
        cm = lanes(32'(st.ctrl), wb_dat_i, wb_sel_i);
        ctl = xu_pkg::ctrl_t'(cm[$bits(xu_pkg::ctrl_t)-1:0]);
        op = ctl.op;
        sel = ctl.sel;
        start = req & wb_we_i & (adr == xu_pkg::OFS_CTRL) & ~busy;
    end

    ////////////////////////////////////////////////////////////////////////
    // execution of one operation
    always_comb
    begin
        fv = st.flags;
        br_pc = st.pc + st.offset + xu_pkg::PC_STEP;
        pcn = st.pc + xu_pkg::PC_STEP;
        stack_n = st.stack;
        ao.res = st.opa;
        ao.fl = st.flags;
        cyc = xu_pkg::CYC_ONE;
        cond = 1'b0;
        is_skip = 1'b0;
        is_br = 1'b0;
        unique case (op)
            xu_pkg::op_add: ao = add8(st.opa, st.opb, 1'b0, st.flags); // RULE1
            xu_pkg::op_add_carry: ao = add8(st.opa, st.opb, st.flags.c, st.flags); // RULE1
            xu_pkg::op_sub,
            xu_pkg::op_subtract_const: ao = sub8(st.opa, st.opb, 1'b0, st.flags, 1'b0); // RULE2
            xu_pkg::op_subtract_borrow,
            xu_pkg::op_subtract_borrow_const:
                ao = sub8(st.opa, st.opb, st.flags.c, st.flags, 1'b1); // RULE3
            xu_pkg::op_and,
            xu_pkg::op_and_immediate: ao = logic8(st.opa & st.opb, st.flags); // RULE4
            xu_pkg::op_or,
            xu_pkg::op_or_immediate: ao = logic8(st.opa | st.opb, st.flags); // RULE4
            xu_pkg::op_xor_registers: ao = logic8(st.opa ^ st.opb, st.flags); // RULE4
            xu_pkg::op_mask_set_bits: ao = logic8(st.opa | st.opb, st.flags); // RULE5
            xu_pkg::op_mask_clear_bits:
                ao = logic8(st.opa & (xu_pkg::ALL_ONES - st.opb), st.flags); // RULE6
            xu_pkg::op_zero_minus_check: ao = logic8(st.opa & st.opa, st.flags); // RULE7
            xu_pkg::op_register_zero: ao = logic8(st.opa ^ st.opa, st.flags); // RULE21
            xu_pkg::op_register_all_ones: ao.res = xu_pkg::ALL_ONES; // RULE21
            xu_pkg::op_bitwise_invert:
            begin
                ao = logic8(xu_pkg::ALL_ONES - st.opa, st.flags); // RULE20
                ao.fl.c = 1'b1; // RULE20
            end
            xu_pkg::op_sign_flip: ao = sub8(8'h00, st.opa, 1'b0, st.flags, 1'b0); // RULE20
            xu_pkg::op_add_one:
            begin
                ao = add8(st.opa, 8'h01, 1'b0, st.flags);
                ao.fl.c = st.flags.c; // RULE21
                ao.fl.h = st.flags.h; // RULE21
            end
            xu_pkg::op_subtract_one:
            begin
                ao = sub8(st.opa, 8'h01, 1'b0, st.flags, 1'b0);
                ao.fl.c = st.flags.c; // RULE21
                ao.fl.h = st.flags.h; // RULE21
            end
            xu_pkg::op_compare,
            xu_pkg::op_compare_const:
            begin
                ao = sub8(st.opa, st.opb, 1'b0, st.flags, 1'b0);
                ao.res = st.opa; // RULE8
            end
            xu_pkg::op_compare_borrow:
            begin
                ao = sub8(st.opa, st.opb, st.flags.c, st.flags, 1'b1);
                ao.res = st.opa; // RULE8
            end
            xu_pkg::op_compare_skip_equal:
            begin
                is_skip = 1'b1;
                cond = (st.opa == st.opb); // RULE9
            end
            xu_pkg::op_skip_reg_bit_low:
            begin
                is_skip = 1'b1;
                cond = ~st.opa[sel]; // RULE10
            end
            xu_pkg::op_skip_reg_bit_high:
            begin
                is_skip = 1'b1;
                cond = st.opa[sel]; // RULE10
            end
            xu_pkg::op_skip_io_bit_low:
            begin
                is_skip = 1'b1;
                cond = ~st.opb[sel]; // RULE11
            end
            xu_pkg::op_skip_io_bit_high:
            begin
                is_skip = 1'b1;
                cond = st.opb[sel]; // RULE11
            end
            xu_pkg::op_branch_flag_high:
            begin
                is_br = 1'b1;
                cond = fv[sel]; // RULE12
            end
            xu_pkg::op_branch_flag_low:
            begin
                is_br = 1'b1;
                cond = ~fv[sel]; // RULE12
            end
            xu_pkg::op_branch_signed_ge:
            begin
                is_br = 1'b1;
                cond = ~(st.flags.n ^ st.flags.v); // RULE13
            end
            xu_pkg::op_branch_signed_lt:
            begin
                is_br = 1'b1;
                cond = st.flags.n ^ st.flags.v; // RULE13
            end
            xu_pkg::op_branch_unsigned_ge,
            xu_pkg::op_branch_carry_low:
            begin
                is_br = 1'b1;
                cond = ~st.flags.c; // RULE14
            end
            xu_pkg::op_branch_unsigned_lt:
            begin
                is_br = 1'b1;
                cond = st.flags.c; // RULE14
            end
            xu_pkg::op_branch_halfcarry_high:
            begin
                is_br = 1'b1;
                cond = st.flags.h; // RULE15
            end
            xu_pkg::op_branch_halfcarry_low:
            begin
                is_br = 1'b1;
                cond = ~st.flags.h; // RULE15
            end
            xu_pkg::op_branch_transfer_high:
            begin
                is_br = 1'b1;
                cond = st.flags.t; // RULE16
            end
            xu_pkg::op_branch_transfer_low:
            begin
                is_br = 1'b1;
                cond = ~st.flags.t; // RULE16
            end
            xu_pkg::op_branch_overflow_high:
            begin
                is_br = 1'b1;
                cond = st.flags.v; // RULE17
            end
            xu_pkg::op_branch_overflow_low:
            begin
                is_br = 1'b1;
                cond = ~st.flags.v; // RULE17
            end
            xu_pkg::op_branch_irq_on:
            begin
                is_br = 1'b1;
                cond = st.flags.i; // RULE18
            end
            xu_pkg::op_branch_irq_off:
            begin
                is_br = 1'b1;
                cond = ~st.flags.i; // RULE18
            end
            xu_pkg::op_relative_jump:
            begin
                pcn = br_pc; // RULE19
                cyc = xu_pkg::CYC_JUMP;
            end
            xu_pkg::op_relative_call:
            begin
                stack_n = pcn; // RULE19
                pcn = br_pc;
                cyc = xu_pkg::CYC_CALL;
            end
            xu_pkg::op_call_exit:
            begin
                pcn = st.stack; // RULE19
                cyc = xu_pkg::CYC_RETURN;
            end
            xu_pkg::op_interrupt_exit:
            begin
                pcn = st.stack; // RULE19
                ao.fl.i = 1'b1; // RULE19
                cyc = xu_pkg::CYC_RETURN;
            end
            default: cyc = xu_pkg::CYC_ONE;
        endcase
        if (is_skip && cond)
        begin
            pcn = st.pc + (ctl.long_skip ? xu_pkg::SKIP_LONG : xu_pkg::SKIP_SHORT); // RULE9
            cyc = xu_pkg::CYC_SKIP; // RULE10
        end
        if (is_br && cond)
        begin
            pcn = br_pc; // RULE12
            cyc = xu_pkg::CYC_TAKEN; // RULE18
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register read mux
    always_comb
    begin
        case (adr)
            xu_pkg::OFS_OPA: rd = 32'(st.opa);
            xu_pkg::OFS_OPB: rd = 32'(st.opb);
            xu_pkg::OFS_CTRL: rd = 32'(st.ctrl);
            xu_pkg::OFS_FLAGS: rd = 32'(st.flags);
            xu_pkg::OFS_PC: rd = 32'(st.pc);
            xu_pkg::OFS_OFFSET: rd = 32'(st.offset);
            xu_pkg::OFS_STACK: rd = 32'(st.stack);
            xu_pkg::OFS_STATUS: rd = 32'({st.last_cyc, 2'b00, st.taken, busy});
            default: rd = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        next_st = st;
        m = 32'h0000_0000;
        next_st.ack = req;
        if (req && !wb_we_i)
        begin
            next_st.dat = rd;
        end
        if (req && wb_we_i)
        begin
            case (adr)
                xu_pkg::OFS_OPA:
                begin
                    m = lanes(32'(st.opa), wb_dat_i, wb_sel_i);
                    next_st.opa = m[7:0];
                end
                xu_pkg::OFS_OPB:
                begin
                    m = lanes(32'(st.opb), wb_dat_i, wb_sel_i);
                    next_st.opb = m[7:0];
                end
                xu_pkg::OFS_FLAGS:
                begin
                    m = lanes(32'(st.flags), wb_dat_i, wb_sel_i);
                    next_st.flags = xu_pkg::flags_t'(m[7:0]);
                end
                xu_pkg::OFS_PC:
                begin
                    m = lanes(32'(st.pc), wb_dat_i, wb_sel_i);
                    next_st.pc = m[xu_pkg::PC_W-1:0];
                end
                xu_pkg::OFS_OFFSET:
                begin
                    m = lanes(32'(st.offset), wb_dat_i, wb_sel_i);
                    next_st.offset = m[xu_pkg::PC_W-1:0];
                end
                xu_pkg::OFS_STACK:
                begin
                    m = lanes(32'(st.stack), wb_dat_i, wb_sel_i);
                    next_st.stack = m[xu_pkg::PC_W-1:0];
                end
                default: m = 32'h0000_0000;
            endcase
        end
        if (start)
        begin
            next_st.ctrl = ctl;
            next_st.opa = ao.res;
            next_st.flags = ao.fl;
            next_st.pc = pcn;
            next_st.stack = stack_n;
            next_st.busy_cnt = cyc;
            next_st.last_cyc = cyc;
            next_st.taken = cond;
        end
        else if (busy)
        begin
            next_st.busy_cnt = st.busy_cnt - 3'h1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            st <= xu_pkg::RESET_STATE;
        end
        else if (ce)
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic fire;
    logic [7:0] chk_sum;
    logic [7:0] chk_sbc;
    logic [7:0] chk_clr;
    assign fire = start & ce;
    assign chk_sum = st.opa + st.opb;
    assign chk_sbc = st.opa - st.opb - {7'h00, st.flags.c};
    assign chk_clr = st.opa & ~st.opb;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    add_sum_a: assert property (fire && op == xu_pkg::op_add |=> // RULE1
        st.opa == $past(chk_sum) && st.busy_cnt == 3'h1)
        else $error("add result wrong");
    sub_carry_a: assert property (fire && op == xu_pkg::op_sub |=> // RULE2
        st.flags.c == ($past(st.opa) < $past(st.opb)))
        else $error("subtract borrow wrong");
    borrow_sub_a: assert property (fire && op == xu_pkg::op_subtract_borrow |=> // RULE3
        st.opa == $past(chk_sbc))
        else $error("borrow subtract wrong");
    logic_keep_a: assert property (fire && op == xu_pkg::op_xor_registers |=> // RULE4
        $stable(st.flags.c) && $stable(st.flags.h) && !st.flags.v)
        else $error("logic op flags wrong");
    clear_mask_a: assert property (fire && op == xu_pkg::op_mask_clear_bits |=> // RULE6
        st.opa == $past(chk_clr))
        else $error("clear bits wrong");
    compare_keep_a: assert property (fire && op == xu_pkg::op_compare |=> // RULE8
        $stable(st.opa) && st.flags.z == ($past(st.opa) == $past(st.opb)))
        else $error("compare wrong");
    skip_equal_a: assert property (fire && op == xu_pkg::op_compare_skip_equal // RULE9
        && st.opa == st.opb |=> st.busy_cnt == 3'h2 && $stable(st.flags))
        else $error("skip timing wrong");
    signed_lt_a: assert property (fire && op == xu_pkg::op_branch_signed_lt // RULE13
        && (st.flags.n ^ st.flags.v) |=> st.pc == $past(br_pc))
        else $error("signed branch wrong");
    carry_untaken_a: assert property (fire && op == xu_pkg::op_branch_unsigned_ge // RULE14
        && st.flags.c |=> st.busy_cnt == 3'h1 && !st.taken)
        else $error("untaken branch wrong");
    return_pc_a: assert property (fire && op == xu_pkg::op_call_exit |=> // RULE19
        st.pc == $past(st.stack) && st.busy_cnt == 3'h4)
        else $error("return wrong");
    invert_flags_a: assert property (fire && op == xu_pkg::op_bitwise_invert |=> // RULE20
        st.flags.c && st.opa == ~$past(st.opa))
        else $error("invert wrong");
    inc_carry_a: assert property (fire && op == xu_pkg::op_add_one |=> // RULE21
        $stable(st.flags.c) && st.flags.v == (st.opa == 8'h80))
        else $error("increment flags wrong");
    busy_count_a: assert property (busy && ce && !start |=>
        st.busy_cnt == $past(st.busy_cnt) - 3'h1)
        else $error("busy count wrong");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");

    call_seen_c: cover property (fire && op == xu_pkg::op_relative_call);
    skip_seen_c: cover property (fire && is_skip && cond);
    branch_seen_c: cover property (fire && is_br && cond);
endmodule
`default_nettype wire

// >>> testbench.sv
/*
 table-driven self-checking bench for the alu and branch execution unit.
 assumes xu_pkg and the unit are compiled first; ce is held high.
*/
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [11:0] cmd;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] fin;
        logic [7:0] res;
        logic [7:0] fout;
        logic [11:0] pc;
        logic [2:0] cyc;
    } row_t;
    logic mclk;
    logic rst;
    logic ce;
    logic wb_cyc_i;
    logic wb_stb_i;
    logic wb_we_i;
    logic [4:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic busy;
    logic [31:0] q;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    // cmd: [11] long skip, [10:8] select, [5:0] op; pc 100, offset -2
    row_t rows [40] = '{
        '{12'h000,8'h0f,8'h01,8'h00,8'h10,8'h20,12'h101,3'h1},
        '{12'h001,8'hff,8'h00,8'h01,8'h00,8'h23,12'h101,3'h1},
        '{12'h002,8'h80,8'h01,8'h00,8'h7f,8'h28,12'h101,3'h1},
        '{12'h004,8'h05,8'h05,8'h03,8'hff,8'h25,12'h101,3'h1},
        '{12'h006,8'hf0,8'h0f,8'h21,8'h00,8'h23,12'h101,3'h1},
        '{12'h00d,8'h01,8'h80,8'h00,8'h81,8'h04,12'h101,3'h1},
        '{12'h00e,8'hff,8'h0f,8'h00,8'hf0,8'h04,12'h101,3'h1},
        '{12'h011,8'h80,8'h00,8'h00,8'h80,8'h04,12'h101,3'h1},
        '{12'h00b,8'h00,8'h00,8'h00,8'hff,8'h05,12'h101,3'h1},
        '{12'h00c,8'h01,8'h00,8'h00,8'hff,8'h25,12'h101,3'h1},
        '{12'h019,8'h10,8'h20,8'h00,8'h10,8'h05,12'h101,3'h1},
        '{12'h010,8'h80,8'h00,8'h01,8'h7f,8'h09,12'h101,3'h1},
        '{12'h013,8'h00,8'h00,8'h3f,8'hff,8'h3f,12'h101,3'h1},
        '{12'h00f,8'h7f,8'h00,8'h01,8'h80,8'h0d,12'h101,3'h1},
        '{12'h00a,8'hf0,8'hff,8'h21,8'h0f,8'h21,12'h101,3'h1},
        '{12'h012,8'h5a,8'h00,8'h0d,8'h00,8'h03,12'h101,3'h1},
        '{12'h120,8'h00,8'h00,8'h02,8'h00,8'h02,12'h0ff,3'h2},
        '{12'h121,8'h00,8'h00,8'h02,8'h00,8'h02,12'h101,3'h1},
        '{12'h022,8'h00,8'h00,8'h0c,8'h00,8'h0c,12'h0ff,3'h2},
        '{12'h023,8'h00,8'h00,8'h04,8'h00,8'h04,12'h0ff,3'h2},
        '{12'h024,8'h00,8'h00,8'h01,8'h00,8'h01,12'h101,3'h1},
        '{12'h025,8'h00,8'h00,8'h01,8'h00,8'h01,12'h0ff,3'h2},
        '{12'h026,8'h00,8'h00,8'h00,8'h00,8'h00,12'h0ff,3'h2},
        '{12'h027,8'h00,8'h00,8'h20,8'h00,8'h20,12'h0ff,3'h2},
        '{12'h028,8'h00,8'h00,8'h20,8'h00,8'h20,12'h101,3'h1},
        '{12'h029,8'h00,8'h00,8'h40,8'h00,8'h40,12'h0ff,3'h2},
        '{12'h02a,8'h00,8'h00,8'h00,8'h00,8'h00,12'h0ff,3'h2},
        '{12'h02b,8'h00,8'h00,8'h08,8'h00,8'h08,12'h0ff,3'h2},
        '{12'h02c,8'h00,8'h00,8'h08,8'h00,8'h08,12'h101,3'h1},
        '{12'h02d,8'h00,8'h00,8'h80,8'h00,8'h80,12'h0ff,3'h2},
        '{12'h02e,8'h00,8'h00,8'h80,8'h00,8'h80,12'h101,3'h1},
        '{12'h018,8'h33,8'h33,8'h00,8'h33,8'h00,12'h102,3'h2},
        '{12'h818,8'h33,8'h33,8'h00,8'h33,8'h00,12'h103,3'h2},
        '{12'h31c,8'h08,8'h00,8'h00,8'h08,8'h00,12'h101,3'h1},
        '{12'h31d,8'h08,8'h00,8'h00,8'h08,8'h00,12'h102,3'h2},
        '{12'h01e,8'h00,8'h00,8'h00,8'h00,8'h00,12'h102,3'h2},
        '{12'h01f,8'h00,8'h00,8'h00,8'h00,8'h00,12'h101,3'h1},
        '{12'h014,8'h00,8'h00,8'h00,8'h00,8'h00,12'h0ff,3'h2},
        '{12'h015,8'h00,8'h00,8'h00,8'h00,8'h00,12'h0ff,3'h3},
        '{12'h017,8'h00,8'h00,8'h00,8'h00,8'h80,12'h055,3'h4}
    };
    alu_and_branch_execution dut (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .busy(busy)
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // classic single cycle, held until ack
    task automatic wb(input logic [4:0] adr, input logic we, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= s;
        wb_dat_i <= d;
        do
        begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50)
            num_errors++;
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [4:0] adr, input logic [31:0] d);
        logic [31:0] r;
        wb(adr, 1'b1, d, 4'hf, r);
    endtask
    task automatic idle_wait();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 20)
        begin
            @(posedge mclk);
            n++;
        end
        chk("busy_end", {31'h0, busy}, 32'h0000_0000);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            results();
        end
    end
    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 5'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0000_0000;
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        wb(xu_pkg::OFS_FLAGS, 1'b0, 32'h0, 4'h0, q);
        chk("reset_flags", q, 32'h0000_0000);
        foreach (rows[i])
        begin
            wr(xu_pkg::OFS_OPA, {24'h0, rows[i].a});
            wr(xu_pkg::OFS_OPB, {24'h0, rows[i].b});
            wr(xu_pkg::OFS_FLAGS, {24'h0, rows[i].fin});
            wr(xu_pkg::OFS_PC, 32'h0000_0100);
            wr(xu_pkg::OFS_OFFSET, 32'h0000_0ffe);
            wr(xu_pkg::OFS_STACK, 32'h0000_0055);
            wr(xu_pkg::OFS_CTRL, {20'h0, rows[i].cmd});
            wb(xu_pkg::OFS_OPA, 1'b0, 32'h0, 4'h0, q);
            chk("result", q, {24'h0, rows[i].res});
            wb(xu_pkg::OFS_FLAGS, 1'b0, 32'h0, 4'h0, q);
            chk("flags", q, {24'h0, rows[i].fout});
            wb(xu_pkg::OFS_PC, 1'b0, 32'h0, 4'h0, q);
            chk("pc", q, {20'h0, rows[i].pc});
            idle_wait();
            wb(xu_pkg::OFS_STATUS, 1'b0, 32'h0, 4'h0, q);
            chk("cycles", {29'h0, q[6:4]}, {29'h0, rows[i].cyc});
        end
        // command during a return is dropped
        wr(xu_pkg::OFS_STACK, 32'h0000_0077);
        wr(xu_pkg::OFS_CTRL, 32'h0000_0016);
        wr(xu_pkg::OFS_CTRL, 32'h0000_0014);
        idle_wait();
        wb(xu_pkg::OFS_PC, 1'b0, 32'h0, 4'h0, q);
        chk("pc_return", q, 32'h0000_0077);
        wb(xu_pkg::OFS_STATUS, 1'b0, 32'h0, 4'h0, q);
        chk("ret_cycles", {29'h0, q[6:4]}, 32'h0000_0004);
        // write with no lanes keeps the operand
        wr(xu_pkg::OFS_OPA, 32'h0000_0011);
        wb(xu_pkg::OFS_OPA, 1'b1, 32'h0000_00aa, 4'h0, q);
        wb(xu_pkg::OFS_OPA, 1'b0, 32'h0, 4'h0, q);
        chk("no_lanes", q, 32'h0000_0011);
        results();
    end
endmodule
`default_nettype wire
